// ---- psb_bridge_model.sv ----
// Bridge switch model that watches the gate drives for leg shorts and power.
`timescale 1ns/1ps
module psb_bridge_model
  import psb_pkg::*;
(
  // Clock
  input  wire logic                sys_clk,
  // Gate drives
  input  wire psb_pkg::psb_gates_t gates,
  // Status
  output logic                     leg_short,
  output logic                     delivering
);
  // A short on either leg latches, so a one-cycle overlap is never lost.
  logic short_seen = 1'b0;
  always @(posedge sys_clk) begin
    if ((gates[3] && gates[2]) || (gates[1] && gates[0])) begin
      short_seen <= 1'b1;
    end
  end
  assign leg_short = short_seen;
  assign delivering = (gates[2] & gates[1]) | (gates[3] & gates[0]);
endmodule

// ---- psb_pkg.sv ----
// Package: constants and carrier types for the phase shift bridge sequencer.
package psb_pkg;

  // ---------------------------------------------------------------------
  // Widths and timing
  // ---------------------------------------------------------------------
  localparam int          PSB_DT_W      = 8;
  localparam int          PSB_CLK_NS    = 8;
  // Default dead time in ns, rounded up to whole clock cycles.
  localparam int          PSB_DT_NS     = 220;
  localparam logic [7:0]  PSB_DT_RST    =
    8'((PSB_DT_NS + PSB_CLK_NS - 1) / PSB_CLK_NS);
  localparam logic [7:0]  PSB_DT_ONE    = 8'h01;
  localparam logic [7:0]  PSB_DT_ZERO   = 8'h00;

  // ---------------------------------------------------------------------
  // Sequencer states
  // ---------------------------------------------------------------------
  typedef enum logic [4:0] {
    PSB_IDLE  = 5'h01,
    PSB_POWER = 5'h02,
    PSB_BDEAD = 5'h04,
    PSB_CIRC  = 5'h08,
    PSB_ADEAD = 5'h10
  } psb_state_t;

  // Gate drive bundle for the four bridge outputs.
  typedef struct packed {
    logic side_a_low_switch_drive;
    logic side_a_high_switch_drive;
    logic side_b_first_drive;
    logic side_b_second_drive;
  } psb_gates_t;

  // Trip and control inputs that arrive from the analog front end.
  typedef struct packed {
    logic modulation_comparator_trip;
    logic overcurrent_trip;
    logic ramp_current_trip;
    logic osc_clock;
    logic shutdown_n;
    logic fault_shutdown;
  } psb_pins_t;

  // Whole state of the sequencer.
  typedef struct packed {
    psb_pins_t           meta;
    psb_pins_t           sync;
    logic                osc_prev;
    psb_state_t          state;
    logic                phase;
    logic [PSB_DT_W-1:0] count;
    psb_gates_t          gates;
  } psb_regs_t;

endpackage

// ---- psb_sequencer.sv ----
// Sequencer for a phase-modulated full bridge with a side A dead time at each cycle end and a side B dead time only after a trip.
`timescale 1ns/1ps
module psb_sequencer (
  // Clock and reset
  input  wire logic                         sys_clk,
  input  wire logic                         arst_n,
  // Oscillator, trips and shutdown, all asynchronous to sys_clk
  input  wire logic                         osc_clock,
  input  wire logic                         modulation_comparator_trip,
  input  wire logic                         overcurrent_trip,
  input  wire logic                         ramp_current_trip,
  input  wire logic                         shutdown_n,
  input  wire logic                         fault_shutdown,
  // Static configuration
  input  wire logic                         current_mode,
  input  wire logic [psb_pkg::PSB_DT_W-1:0] side_a_delay_setting,
  input  wire logic [psb_pkg::PSB_DT_W-1:0] side_b_delay_setting,
  // Gate drives and role phase
  output psb_pkg::psb_gates_t               gates,
  output logic                              output_phase
);
  import psb_pkg::*;

  psb_regs_t  r;
  psb_regs_t  next_r;
  psb_pins_t  pins_in;
  logic       osc_rise;
  logic       trip;
  logic       halt;

  // ---------------------------------------------------------------------
  // Combinational helpers
  // ---------------------------------------------------------------------
  function automatic logic [PSB_DT_W-1:0] dt_load(
    input logic [PSB_DT_W-1:0] setting);
    // A zero setting still gives one cycle of separation.
    dt_load = (setting == PSB_DT_ZERO) ? PSB_DT_ONE : setting;
  endfunction

  function automatic psb_gates_t gates_for(input psb_state_t st,
                                           input logic ph);
    psb_gates_t g;
    g = '0;
    case (st)
      PSB_POWER: begin
        g.side_a_high_switch_drive = ~ph;
        g.side_a_low_switch_drive  = ph;
        g.side_b_first_drive       = ~ph;
        g.side_b_second_drive      = ph;
      end
      PSB_BDEAD: begin
        g.side_a_high_switch_drive = ~ph;
        g.side_a_low_switch_drive  = ph;
      end
      PSB_CIRC: begin
        g.side_a_high_switch_drive = ~ph;
        g.side_a_low_switch_drive  = ph;
        g.side_b_first_drive       = ph;
        g.side_b_second_drive      = ~ph;
      end
      PSB_ADEAD: begin
        g.side_b_first_drive       = ph;
        g.side_b_second_drive      = ~ph;
      end
      default: g = '0;
    endcase
    gates_for = g;
  endfunction

  always_comb begin
    pins_in.modulation_comparator_trip = modulation_comparator_trip;
    pins_in.overcurrent_trip           = overcurrent_trip;
    pins_in.ramp_current_trip          = ramp_current_trip;
    pins_in.osc_clock                  = osc_clock;
    pins_in.shutdown_n                 = shutdown_n;
    pins_in.fault_shutdown             = fault_shutdown;
  end

  assign osc_rise = r.sync.osc_clock & ~r.osc_prev;
  assign trip = (current_mode ? r.sync.ramp_current_trip
                              : r.sync.modulation_comparator_trip)
              | r.sync.overcurrent_trip;
  assign halt = ~r.sync.shutdown_n | r.sync.fault_shutdown;

  // ---------------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------------
  always_comb begin
    next_r          = r;
    next_r.meta     = pins_in;
    next_r.sync     = r.meta;
    next_r.osc_prev = r.sync.osc_clock;
    if (r.count != PSB_DT_ZERO) begin
      next_r.count = r.count - PSB_DT_ONE;
    end
    if (halt) begin
      next_r.state = PSB_IDLE;
      next_r.count = PSB_DT_ZERO;
    end else begin
      case (r.state)
        PSB_IDLE: begin
          if (osc_rise) begin
            next_r.state = PSB_POWER;
          end
        end
        PSB_POWER: begin
          if (osc_rise) begin
            // Late trip: clock edge ends the cycle through side A.
            next_r.state = PSB_ADEAD;
            next_r.count = dt_load(side_a_delay_setting);
          end else if (trip) begin
            next_r.state = PSB_BDEAD;
            next_r.count = dt_load(side_b_delay_setting);
          end
        end
        PSB_BDEAD: begin
          if (r.count == PSB_DT_ONE) begin
            next_r.state = PSB_CIRC;
          end
        end
        PSB_CIRC: begin
          if (osc_rise) begin
            next_r.state = PSB_ADEAD;
            next_r.count = dt_load(side_a_delay_setting);
          end
        end
        PSB_ADEAD: begin
          if (r.count == PSB_DT_ONE) begin
            next_r.state = PSB_POWER;
            next_r.phase = ~r.phase;
          end
        end
        default: next_r.state = PSB_IDLE;
      endcase
    end
    next_r.gates = gates_for(next_r.state, next_r.phase);
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      r       <= '0;
      r.state <= PSB_IDLE;
    end else begin
      r <= next_r;
    end
  end

  assign gates        = r.gates;
  assign output_phase = r.phase;

  // ---------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!arst_n);

  // Steps of one power cycle, as seen on the registered state.
  sequence trip_taken_s;
    r.state == PSB_POWER && trip && !osc_rise && !halt;
  endsequence

  sequence b_off_s;
    !gates.side_b_first_drive && !gates.side_b_second_drive;
  endsequence

  sequence bdead_step_s;
    r.state == PSB_BDEAD && r.count > PSB_DT_ONE && !halt;
  endsequence

  sequence bdead_last_s;
    r.state == PSB_BDEAD && r.count == PSB_DT_ONE && !halt;
  endsequence

  sequence adead_last_s;
    r.state == PSB_ADEAD && r.count == PSB_DT_ONE && !halt;
  endsequence

  // In current mode only the ramp and limit trips may end power.
  sequence mode_masked_s;
    r.state == PSB_POWER && current_mode && !osc_rise && !halt
    && !r.sync.ramp_current_trip && !r.sync.overcurrent_trip;
  endsequence

  side_a_excl_a: assert property (
    !(gates.side_a_low_switch_drive && gates.side_a_high_switch_drive))
    else $error("Side A outputs both high.");
  side_b_excl_a: assert property (
    !(gates.side_b_first_drive && gates.side_b_second_drive))
    else $error("Side B outputs both high.");
  halt_off_a: assert property (halt |=> gates == '0)
    else $error("Outputs active during shutdown.");
  fault_off_a: assert property (
    r.sync.fault_shutdown |=> gates == '0)
    else $error("Outputs active during fault.");
  trip_drop_a: assert property (
    trip_taken_s |=> (r.state == PSB_BDEAD) ##0 b_off_s)
    else $error("Trip did not end power.");
  bdead_load_a: assert property (
    trip_taken_s |=> r.count == dt_load($past(side_b_delay_setting)))
    else $error("Side B dead time not loaded.");
  bdead_step_a: assert property (
    bdead_step_s |=> r.state == PSB_BDEAD
    && r.count == $past(r.count) - PSB_DT_ONE)
    else $error("Side B dead time cut short.");
  bdead_end_a: assert property (
    bdead_last_s |=> r.state == PSB_CIRC
    && gates.side_b_first_drive == r.phase
    && gates.side_b_second_drive != r.phase)
    else $error("Side B complement late.");
  clk_adead_a: assert property (
    r.state == PSB_CIRC && osc_rise && !halt |=> r.state == PSB_ADEAD
    && !gates.side_a_low_switch_drive && !gates.side_a_high_switch_drive
    && r.count == dt_load($past(side_a_delay_setting)))
    else $error("Clock edge did not start side A dead time.");
  roles_swap_a: assert property (
    adead_last_s |=> r.state == PSB_POWER && r.phase != $past(r.phase))
    else $error("Roles did not swap.");
  phase_hold_a: assert property (
    !(r.state == PSB_ADEAD && r.count == PSB_DT_ONE && !halt)
    |=> $stable(r.phase))
    else $error("Role state toggled outside a period end.");
  start_diag_a: assert property (
    r.state == PSB_POWER && !r.phase
    |-> gates.side_a_high_switch_drive && gates.side_b_first_drive)
    else $error("Power cycle not on starting diagonal.");
  mode_mask_a: assert property (
    mode_masked_s |=> r.state == PSB_POWER)
    else $error("Unselected trip ended power.");

endmodule

// ---- psb_testbench.sv ----
// Self-checking bench for the phase shift bridge sequencer.
`timescale 1ns/1ps
module testbench;
  import psb_pkg::*;
  logic sys_clk, arst_n, osc, mtrip, otrip, rtrip, sdn_n, fault, cmode;
  logic [7:0] set_a, set_b;
  psb_gates_t gates;
  logic phase, leg_short, delivering;
  int failures, check_count, cycles, seed, p, n, na, nb, i;
  psb_sequencer dut (.sys_clk(sys_clk), .arst_n(arst_n), .osc_clock(osc),
    .modulation_comparator_trip(mtrip), .overcurrent_trip(otrip),
    .ramp_current_trip(rtrip), .shutdown_n(sdn_n), .fault_shutdown(fault),
    .current_mode(cmode), .side_a_delay_setting(set_a),
    .side_b_delay_setting(set_b), .gates(gates), .output_phase(phase));
  psb_bridge_model bridge (.sys_clk(sys_clk), .gates(gates),
    .leg_short(leg_short), .delivering(delivering));
  // ---------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------
  task automatic test_done;
    if (failures == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic check(input string what, input logic [7:0] seen,
                       input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  function automatic logic [3:0] pw(input int ph);
    return (ph == 1) ? 4'b1001 : 4'b0110;
  endfunction
  function automatic logic [3:0] cc(input int ph);
    return (ph == 1) ? 4'b1010 : 4'b0101;
  endfunction
  function automatic logic [1:0] leg(input int a_side);
    return (a_side == 1) ? gates[3:2] : gates[1:0];
  endfunction
  task automatic wait_gates(input logic [3:0] pat, input string what);
    int k;
    k = 0;
    while (gates !== pat && k < 40) begin
      @(negedge sys_clk);
      k++;
    end
    check(what, 8'(gates), 8'(pat));
  endtask
  // Counts the cycles that one side spends with both drives low.
  task automatic dead(input int a_side, output int cnt);
    int k;
    k = 0;
    cnt = 0;
    while (leg(a_side) !== 2'b00 && k < 40) begin
      @(negedge sys_clk);
      k++;
    end
    while (leg(a_side) === 2'b00 && cnt < 300) begin
      @(negedge sys_clk);
      cnt++;
    end
  endtask
  task automatic osc_pulse;
    osc = 1'b1;
    repeat (8) @(negedge sys_clk);
    osc = 1'b0;
  endtask
  // ---------------------------------------------------------------------
  // Stimulus
  // ---------------------------------------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      test_done();
    end
  end
  initial begin
    {osc, mtrip, otrip, rtrip, fault, cmode} = '0;
    {sdn_n, arst_n} = 2'b10;
    set_a = 8'h03;
    set_b = 8'h02;
    seed = 32'h7C11;
    p = 0;
    repeat (16) @(negedge sys_clk);
    arst_n = 1'b1;
    check("reset gates", 8'(gates), 8'h00);
    check("reset phase", 8'(phase), 8'h00);
    osc_pulse();
    wait_gates(pw(0), "first power");
    for (i = 0; i < 7; i++) begin
      na = (i == 0) ? 0 : ($random(seed) & 15);
      nb = (i == 1) ? 0 : ($random(seed) & 15);
      set_a = 8'(na);
      set_b = 8'(nb);
      cmode = (i % 3 == 2);
      // The trip of the mode not selected must leave power on.
      {rtrip, mtrip} = cmode ? 2'b01 : 2'b10;
      repeat (10) @(negedge sys_clk);
      check("mode select", 8'(gates), 8'(pw(p)));
      {rtrip, mtrip} = 2'b00;
      repeat (4) @(negedge sys_clk);
      {rtrip, otrip, mtrip} = 3'b001 << (i % 3);
      dead(0, n);
      check("b dead", 8'(n), 8'((nb == 0) ? 1 : nb));
      {rtrip, otrip, mtrip} = 3'b000;
      wait_gates(cc(p), "circulate");
      osc = 1'b1;
      dead(1, n);
      osc = 1'b0;
      check("a dead", 8'(n), 8'((na == 0) ? 1 : na));
      p = 1 - p;
      wait_gates(pw(p), "next power");
      check("phase", 8'(phase), 8'(p));
    end
    for (i = 0; i < 2; i++) begin
      if (i == 0) sdn_n = 1'b0;
      else fault = 1'b1;
      wait_gates(4'b0000, "halt entry");
      repeat (10) @(negedge sys_clk);
      check("halt hold", 8'(gates), 8'h00);
      {sdn_n, fault} = 2'b10;
      repeat (5) @(negedge sys_clk);
      osc_pulse();
      wait_gates(pw(p), "restart");
    end
    // Reset in mid-run clears the role state and holds every drive low.
    arst_n = 1'b0;
    @(negedge sys_clk);
    check("reset drives", 8'(gates), 8'h00);
    check("reset roles", 8'(phase), 8'h00);
    arst_n = 1'b1;
    osc_pulse();
    wait_gates(pw(0), "reset restart");
    check("bridge short", 8'(leg_short), 8'h00);
    check("delivering", 8'(delivering), 8'h01);
    test_done();
  end
endmodule
